// file: logic/sgb_clock_ctrl.sv
// sleep clock keep enables, backup domain control and clock status registers on APB
// assumes APB master in the core domain; separate backup and power resets are async active low
`include "sgb_params.svh"
module sgb_clock_ctrl (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_arst_n,
  input  wire logic                 i_backup_rst_n,
  input  wire logic                 i_power_rst_n,
  input  wire sgb_pkg::sgb_apb_req_t i_apb,
  output sgb_pkg::sgb_apb_rsp_t     o_apb,
  input  wire logic                 i_backup_write_unlock,
  input  wire logic                 i_core_sleeping,
  input  wire logic [31:0]          i_periph_run_en,
  input  wire logic [6:0]           i_reset_cause_evt,
  input  wire logic                 i_slow_xtal_stable,
  input  wire logic                 i_slow_xtal_tick,
  input  wire logic                 i_slow_rc_stable,
  input  wire logic                 i_slow_rc_tick,
  output logic [31:0]               o_periph_clk_gate,
  output logic                      o_backup_domain_reset,
  output logic                      o_rtc_clock_on,
  output sgb_pkg::sgb_rtc_src_t     o_rtc_source_select,
  output logic                      o_slow_xtal_on,
  output logic                      o_slow_xtal_bypass,
  output logic                      o_slow_xtal_drive_mode,
  output logic                      o_slow_rc_on
);
  import sgb_pkg::*;

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic [31:0]    sleep_keep;
    logic           slow_rc_on;
    sgb_bus_state_t bus;
    logic [1:0]     wait_cnt;
    logic           last_slow;
    logic [31:0]    rdata;
  } sgb_sys_t;

  typedef struct packed {
    logic         backup_soft_reset;
    logic         rtc_clock_on;
    sgb_rtc_src_t rtc_source_select;
    logic         slow_xtal_drive_mode;
    logic         slow_xtal_bypass;
    logic         slow_xtal_on;
  } sgb_bkp_t;

  sgb_sys_t   sys_r;
  sgb_sys_t   sys_nxt;
  sgb_bkp_t   bkp_r;
  sgb_bkp_t   bkp_nxt;
  logic [6:0] cause_r;
  logic [6:0] cause_nxt;
  logic       xtal_ready;
  logic       rc_ready;
  logic       bkp_rst_n;

  // byte-lane write merge
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  function automatic logic is_slow(input logic [11:0] a);
    return (a == `SGB_OFF_BACKUP_CTRL) || (a == `SGB_OFF_CLK_STATUS);
  endfunction : is_slow

  // ==========================================================================
  // APB slave
  // ==========================================================================
  logic        acc;
  logic        do_acc;
  logic [31:0] wv;
  logic [31:0] bkp_rd;
  logic [31:0] sts_rd;

  assign acc = i_apb.psel && i_apb.penable;

  always_comb begin
    bkp_rd = '0;
    bkp_rd[`SGB_BIT_BACKUP_RESET]                 = bkp_r.backup_soft_reset;
    bkp_rd[`SGB_BIT_RTC_ON]                       = bkp_r.rtc_clock_on;
    bkp_rd[`SGB_BIT_SRC_HI:`SGB_BIT_SRC_LO]       = bkp_r.rtc_source_select;
    bkp_rd[`SGB_BIT_DRIVE_MODE]                   = bkp_r.slow_xtal_drive_mode;
    bkp_rd[`SGB_BIT_BYPASS]                       = bkp_r.slow_xtal_bypass;
    bkp_rd[`SGB_BIT_XTAL_READY]                   = xtal_ready;
    bkp_rd[`SGB_BIT_XTAL_ON]                      = bkp_r.slow_xtal_on;
    sts_rd = '0;
    sts_rd[31:`SGB_BIT_CAUSE_LO]                  = cause_r;
    sts_rd[`SGB_BIT_RC_READY]                     = rc_ready;
    sts_rd[`SGB_BIT_RC_ON]                        = sys_r.slow_rc_on;
  end

  always_comb begin
    sys_nxt = sys_r;
    do_acc  = 1'b0;
    wv      = '0;
    case (sys_r.bus)
      SGB_IDLE: begin
        if (acc) begin
          // back-to-back access to the slow registers is stretched
          if (is_slow(i_apb.paddr) && sys_r.last_slow) begin
            sys_nxt.bus      = SGB_WAIT;
            sys_nxt.wait_cnt = `SGB_MAX_WAIT - 2'd1;
          end else begin
            do_acc = 1'b1;
          end
        end
      end
      SGB_WAIT: begin
        if (sys_r.wait_cnt == 2'd0) begin
          do_acc      = 1'b1;
          sys_nxt.bus = SGB_IDLE;
        end else begin
          sys_nxt.wait_cnt = sys_r.wait_cnt - 2'd1;
        end
      end
      default: begin
        sys_nxt.bus = SGB_IDLE;
      end
    endcase
    // read data is captured from the setup cycle on, so prdata leaves a flop with no wait
    if (i_apb.psel && !do_acc) begin
      case (i_apb.paddr)
        `SGB_OFF_SLEEP_KEEP: sys_nxt.rdata = sys_r.sleep_keep;
        `SGB_OFF_BACKUP_CTRL: sys_nxt.rdata = bkp_rd;
        `SGB_OFF_CLK_STATUS: sys_nxt.rdata = sts_rd;
        default: sys_nxt.rdata = '0;
      endcase
    end
    if (do_acc) begin
      sys_nxt.last_slow = is_slow(i_apb.paddr);
      if (i_apb.pwrite && i_apb.paddr == `SGB_OFF_SLEEP_KEEP) begin
        // reserved bits are kept at zero whatever software writes
        wv = merge(sys_r.sleep_keep, i_apb.pwdata, i_apb.pstrb);
        sys_nxt.sleep_keep = wv & `SGB_SLEEP_KEEP_MASK;
      end
      if (i_apb.pwrite && i_apb.paddr == `SGB_OFF_CLK_STATUS) begin
        wv = merge(sts_rd, i_apb.pwdata, i_apb.pstrb);
        sys_nxt.slow_rc_on = wv[`SGB_BIT_RC_ON];
      end
    end else if (!i_apb.psel) begin
      // a cycle with no transfer at all, or a completed access to a register that is not slow, breaks the back-to-back chain
      sys_nxt.last_slow = 1'b0;
    end
  end

  // single-cycle write decode shared by the other register groups
  logic        wr_bkp;
  logic        wr_sts;
  logic [31:0] wv_bkp;
  logic [31:0] wv_sts;
  assign wr_bkp = do_acc && i_apb.pwrite && i_apb.paddr == `SGB_OFF_BACKUP_CTRL;
  assign wr_sts = do_acc && i_apb.pwrite && i_apb.paddr == `SGB_OFF_CLK_STATUS;
  assign wv_bkp = merge(bkp_rd, i_apb.pwdata, i_apb.pstrb);
  assign wv_sts = merge(sts_rd, i_apb.pwdata, i_apb.pstrb);

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sys_r            <= '0;
      sys_r.sleep_keep <= `SGB_SLEEP_KEEP_RST;
    end else begin
      sys_r <= sys_nxt;
    end
  end

  assign o_apb.pready  = do_acc;
  assign o_apb.prdata  = sys_r.rdata;
  assign o_apb.pslverr = 1'b0;

  // ==========================================================================
  // backup domain control
  // ==========================================================================
  // soft reset clears the other backup bits but keeps itself until written 0
  always_comb begin
    bkp_nxt = bkp_r;
    if (wr_bkp) begin
      bkp_nxt.backup_soft_reset = wv_bkp[`SGB_BIT_BACKUP_RESET];
      bkp_nxt.slow_xtal_drive_mode = wv_bkp[`SGB_BIT_DRIVE_MODE];
      if (i_backup_write_unlock) begin
        bkp_nxt.rtc_clock_on = wv_bkp[`SGB_BIT_RTC_ON];
        if (bkp_r.rtc_source_select == SGB_SRC_NONE) begin
          bkp_nxt.rtc_source_select =
            sgb_rtc_src_t'(wv_bkp[`SGB_BIT_SRC_HI:`SGB_BIT_SRC_LO]);
        end
        if (!bkp_r.slow_xtal_on) begin
          bkp_nxt.slow_xtal_bypass = wv_bkp[`SGB_BIT_BYPASS];
        end
        bkp_nxt.slow_xtal_on = wv_bkp[`SGB_BIT_XTAL_ON];
      end
    end
    if (bkp_nxt.backup_soft_reset) begin
      bkp_nxt                   = '0;
      bkp_nxt.backup_soft_reset = 1'b1;
    end
  end

  assign bkp_rst_n = i_backup_rst_n;

  // system reset does not reach these flops
  always_ff @(posedge i_core_clk or negedge bkp_rst_n) begin
    if (!bkp_rst_n) begin
      bkp_r <= '0;
    end else begin
      bkp_r <= bkp_nxt;
    end
  end

  sgb_ready_tracker u_xtal_ready (
    .i_core_clk   (i_core_clk),
    .i_arst_n     (bkp_rst_n),
    .i_enable     (bkp_r.slow_xtal_on),
    .i_stable     (i_slow_xtal_stable),
    .i_osc_tick   (i_slow_xtal_tick),
    .i_off_cycles (`SGB_XTAL_OFF_CYCLES),
    .o_ready      (xtal_ready)
  );

  sgb_ready_tracker u_rc_ready (
    .i_core_clk   (i_core_clk),
    .i_arst_n     (i_arst_n),
    .i_enable     (sys_r.slow_rc_on),
    .i_stable     (i_slow_rc_stable),
    .i_osc_tick   (i_slow_rc_tick),
    .i_off_cycles (`SGB_RC_OFF_CYCLES),
    .o_ready      (rc_ready)
  );

  // ==========================================================================
  // reset cause flags
  // ==========================================================================
  // a cause arriving with the clear strobe survives
  always_comb begin
    cause_nxt = cause_r;
    if (wr_sts && wv_sts[`SGB_BIT_CLEAR_CAUSES]) begin
      cause_nxt = '0;
    end
    cause_nxt = cause_nxt | i_reset_cause_evt;
  end

  always_ff @(posedge i_core_clk or negedge i_power_rst_n) begin
    if (!i_power_rst_n) begin
      cause_r <= `SGB_CAUSE_RST;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  // converter bit 8 is treated like every other keep bit
  assign o_periph_clk_gate = i_periph_run_en &
                             ({32{!i_core_sleeping}} | sys_r.sleep_keep);
  assign o_backup_domain_reset  = bkp_r.backup_soft_reset;
  assign o_rtc_clock_on         = bkp_r.rtc_clock_on;
  assign o_rtc_source_select    = bkp_r.rtc_source_select;
  assign o_slow_xtal_on         = bkp_r.slow_xtal_on;
  assign o_slow_xtal_bypass     = bkp_r.slow_xtal_bypass;
  assign o_slow_xtal_drive_mode = bkp_r.slow_xtal_drive_mode;
  assign o_slow_rc_on           = sys_r.slow_rc_on;
endmodule : sgb_clock_ctrl

// file: shared/sgb_params.svh
// offsets, field positions, reset values and timing counts for the sleep-gating block
// assumes inclusion by bare name from the package and the design files
`ifndef SGB_PARAMS_SVH
`define SGB_PARAMS_SVH
`define SGB_OFF_SLEEP_KEEP    12'h064
`define SGB_OFF_BACKUP_CTRL   12'h070
`define SGB_OFF_CLK_STATUS    12'h074
`define SGB_SLEEP_KEEP_RST    32'h0007_7930
`define SGB_SLEEP_KEEP_MASK   32'h0017_7931
`define SGB_BACKUP_CTRL_RST   32'h0000_0000
`define SGB_CLK_STATUS_RST    32'h0E00_0000
`define SGB_BIT_BACKUP_RESET  16
`define SGB_BIT_RTC_ON        15
`define SGB_BIT_SRC_HI        9
`define SGB_BIT_SRC_LO        8
`define SGB_BIT_DRIVE_MODE    3
`define SGB_BIT_BYPASS        2
`define SGB_BIT_XTAL_READY    1
`define SGB_BIT_XTAL_ON       0
`define SGB_BIT_CLEAR_CAUSES  24
`define SGB_BIT_CAUSE_LO      25
`define SGB_BIT_RC_READY      1
`define SGB_BIT_RC_ON         0
`define SGB_XTAL_OFF_CYCLES   3'd6
`define SGB_RC_OFF_CYCLES     3'd3
`define SGB_MAX_WAIT          2'd3
`define SGB_CAUSE_RST         7'h07
`endif

// file: shared/sgb_pkg.sv
// types shared by the sleep-gating and backup clock control block
// assumes sgb_params.svh is on the include path
package sgb_pkg;
  `include "sgb_params.svh"

  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } sgb_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } sgb_apb_rsp_t;

  typedef enum logic [1:0] {
    SGB_SRC_NONE,
    SGB_SRC_SLOW_XTAL,
    SGB_SRC_SLOW_RC,
    SGB_SRC_FAST_XTAL_DIV
  } sgb_rtc_src_t;

  typedef enum logic [1:0] {
    SGB_IDLE,
    SGB_WAIT,
    SGB_DONE
  } sgb_bus_state_t;
endpackage : sgb_pkg

// file: logic/sgb_ready_tracker.sv
// oscillator ready tracker: ready follows stable while enabled, falls a fixed count after enable drops
// assumes osc_tick is a one-cycle pulse per oscillator cycle in the core clock domain
module sgb_ready_tracker (
  input  wire logic       i_core_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_enable,
  input  wire logic       i_stable,
  input  wire logic       i_osc_tick,
  input  wire logic [2:0] i_off_cycles,
  output logic            o_ready
);
  import sgb_pkg::*;

  typedef struct packed {
    logic       ready;
    logic [2:0] cnt;
  } sgb_trk_t;

  sgb_trk_t st_r;
  sgb_trk_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (i_enable) begin
      st_nxt.ready = i_stable;
      st_nxt.cnt   = 3'h0;
    end else if (st_r.ready && i_osc_tick) begin
      // count oscillator cycles after the enable is cleared
      if (st_r.cnt + 3'h1 >= i_off_cycles) begin
        st_nxt.ready = 1'b0;
        st_nxt.cnt   = 3'h0;
      end else begin
        st_nxt.cnt = st_r.cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_ready = st_r.ready;
endmodule : sgb_ready_tracker

// file: bench/sgb_clock_ctrl_asserts.sv
// port checker for the sleep-gating and backup clock block
// assumes it is bound onto sgb_clock_ctrl and sees that module's ports only
module sgb_clock_ctrl_asserts (
  input wire logic                  i_core_clk,
  input wire logic                  i_arst_n,
  input wire logic                  i_backup_rst_n,
  input wire sgb_pkg::sgb_apb_req_t i_apb,
  input wire sgb_pkg::sgb_apb_rsp_t o_apb,
  input wire logic                  i_backup_write_unlock,
  input wire logic                  i_core_sleeping,
  input wire logic [31:0]           i_periph_run_en,
  input wire logic [31:0]           o_periph_clk_gate,
  input wire logic                  o_backup_domain_reset,
  input wire logic                  o_rtc_clock_on,
  input wire sgb_pkg::sgb_rtc_src_t o_rtc_source_select,
  input wire logic                  o_slow_xtal_on,
  input wire logic                  o_slow_xtal_bypass,
  input wire logic                  o_slow_xtal_drive_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  import sgb_pkg::*;
  logic       bk_acc;
  logic [6:0] bk_out;
  assign bk_acc = i_apb.paddr == 12'h070 || i_apb.paddr == 12'h074;
  assign bk_out = {o_backup_domain_reset, o_rtc_clock_on, o_rtc_source_select,
                   o_slow_xtal_on, o_slow_xtal_bypass, o_slow_xtal_drive_mode};
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_arst_n);
  // ==========
  // bus answers
  property p_fast_ready;
    $rose(i_apb.penable) && i_apb.psel && i_apb.paddr == 12'h064 |-> o_apb.pready;
  endproperty
  a_fast_ready: assert property (p_fast_ready) else $error("sleep keep answer late");
  property p_slow_wait;
    $rose(i_apb.penable) && i_apb.psel && bk_acc |-> ##[0:3] o_apb.pready;
  endproperty
  a_slow_wait: assert property (p_slow_wait) else $error("too many wait states");
  // ==========
  // backup domain; only the backup reset disables these, system reset must not matter
  property p_soft_reset;
    disable iff (!i_backup_rst_n) o_backup_domain_reset && $past(o_backup_domain_reset)
      |-> bk_out[5:0] == 6'h00;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("backup bits alive in reset");
  property p_src_lock;
    disable iff (!i_backup_rst_n) o_rtc_source_select != SGB_SRC_NONE
      |=> o_backup_domain_reset || o_rtc_source_select == $past(o_rtc_source_select);
  endproperty
  a_src_lock: assert property (p_src_lock) else $error("source changed after lock");
  property p_write_lock;
    disable iff (!i_backup_rst_n) !i_backup_write_unlock
      |=> o_backup_domain_reset || $stable({o_rtc_clock_on, bk_out[4:1]});
  endproperty
  a_write_lock: assert property (p_write_lock) else $error("locked bit changed");
  property p_bypass_lock;
    disable iff (!i_backup_rst_n) o_slow_xtal_on |=> o_backup_domain_reset || $stable(o_slow_xtal_bypass);
  endproperty
  a_bypass_lock: assert property (p_bypass_lock) else $error("bypass changed while on");
  property p_sys_keep;
    disable iff (!i_backup_rst_n) !i_arst_n |=> $stable(bk_out);
  endproperty
  a_sys_keep: assert property (p_sys_keep) else $error("system reset hit backup bits");
  // ==========
  // clock gates
  property p_gate_awake;
    !i_core_sleeping |-> o_periph_clk_gate == i_periph_run_en;
  endproperty
  a_gate_awake: assert property (p_gate_awake) else $error("gate wrong while awake");
endmodule : sgb_clock_ctrl_asserts

bind sgb_clock_ctrl sgb_clock_ctrl_asserts u_chk (
  .i_core_clk, .i_arst_n, .i_backup_rst_n, .i_apb, .o_apb, .i_backup_write_unlock,
  .i_core_sleeping, .i_periph_run_en, .o_periph_clk_gate, .o_backup_domain_reset,
  .o_rtc_clock_on, .o_rtc_source_select, .o_slow_xtal_on, .o_slow_xtal_bypass,
  .o_slow_xtal_drive_mode
);

// file: bench/sgb_clock_ctrl_test.sv
// self-checking bench for the sleep-gating and backup clock block
// assumes the package and the bound checker are compiled before it
`define chk(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module sgb_clock_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sgb_pkg::*;
  typedef struct packed {
    logic        w;
    logic [11:0] a;
    logic [31:0] d;
    logic [3:0]  s;
    logic [31:0] e;
  } sgb_row_t;
  logic         clk = 1'b0;
  logic         arst_n = 1'b0;
  logic         bk_n = 1'b0;
  logic         pw_n = 1'b0;
  logic         unlock = 1'b1;
  logic         sleeping = 1'b0;
  logic [31:0]  run_en = 32'hFFFF_FFFF;
  logic [6:0]   evt = 7'h00;
  logic [1:0]   st = 2'h0;
  logic [1:0]   tk = 2'h0;
  sgb_apb_req_t req = '0;
  sgb_apb_rsp_t rsp;
  logic [31:0]  gate;
  logic [31:0]  r;
  int           lat;
  int           failures = 0;
  int           n_compared = 0;
  // loop cases: optional write, then read back
  sgb_row_t rows [8] = '{
    '{1'b0, 12'h064, 32'h0, 4'h0, 32'h0007_7930},
    '{1'b1, 12'h064, 32'h0017_7931, 4'hF, 32'h0017_7931},
    '{1'b1, 12'h064, 32'h0, 4'h2, 32'h0017_0031},
    '{1'b1, 12'h068, 32'hFFFF_FFFF, 4'hF, 32'h0},
    '{1'b1, 12'h070, 32'h0000_8101, 4'hF, 32'h0000_8101},
    '{1'b1, 12'h070, 32'h0000_0204, 4'hF, 32'h0000_0100},
    '{1'b1, 12'h070, 32'h0000_010C, 4'hF, 32'h0000_010C},
    '{1'b0, 12'h074, 32'h0, 4'h0, 32'h0E00_0000}
  };

  sgb_clock_ctrl dut (
    .i_core_clk(clk), .i_arst_n(arst_n), .i_backup_rst_n(bk_n), .i_power_rst_n(pw_n),
    .i_apb(req), .o_apb(rsp), .i_backup_write_unlock(unlock), .i_core_sleeping(sleeping),
    .i_periph_run_en(run_en), .i_reset_cause_evt(evt), .i_slow_xtal_stable(st[0]),
    .i_slow_xtal_tick(tk[0]), .i_slow_rc_stable(st[1]), .i_slow_rc_tick(tk[1]),
    .o_periph_clk_gate(gate), .o_backup_domain_reset(), .o_rtc_clock_on(),
    .o_rtc_source_select(), .o_slow_xtal_on(), .o_slow_xtal_bypass(),
    .o_slow_xtal_drive_mode(), .o_slow_rc_on());

  always #2 clk = ~clk;

  // ==========
  // bus tasks; entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input bit b2b = 1'b0);
    req <= '{a, 1'b1, 1'b0, w, d, s};
    @(posedge clk);
    req.penable <= 1'b1;
    lat = 0;
    // pready and prdata are read at the edge itself, before that edge's updates land
    do begin
      @(posedge clk);
      lat++;
    end while (rsp.pready !== 1'b1);
    r = rsp.prdata;
    if (!b2b) begin
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(posedge clk);
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    `chk(r, e)
  endtask : rd

  task automatic tick(input bit rc, input int n);
    repeat (n) begin
      tk <= rc ? 2'h2 : 2'h1;
      @(posedge clk);
      tk <= 2'h0;
      @(posedge clk);
    end
  endtask : tick

  task automatic end_sim;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    end_sim();
  end

  // ==========
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    bk_n <= 1'b1;
    pw_n <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d, rows[i].s);
      rd(rows[i].a, rows[i].e);
    end
    sleeping <= 1'b1;
    @(posedge clk);
    `chk(gate, 32'h0017_0031)
    wr(12'h064, 32'h0000_0100);
    `chk(gate, 32'h0000_0100)
    run_en <= 32'h0000_FFFF;
    sleeping <= 1'b0;
    @(posedge clk);
    `chk(gate, 32'h0000_FFFF)
    apb(1'b0, 12'h070, 32'h0, 4'h0, 1'b1);
    `chk(lat, 1)
    apb(1'b0, 12'h074, 32'h0, 4'h0);
    `chk(lat, 4)
    unlock <= 1'b0;
    wr(12'h070, 32'h0000_8001);
    rd(12'h070, 32'h0000_0104);
    unlock <= 1'b1;
    st <= 2'h3;
    wr(12'h070, 32'h0000_0105);
    rd(12'h070, 32'h0000_0107);
    wr(12'h070, 32'h0000_0104);
    tick(1'b0, 5);
    rd(12'h070, 32'h0000_0106);
    tick(1'b0, 1);
    rd(12'h070, 32'h0000_0104);
    wr(12'h074, 32'h1);
    rd(12'h074, 32'h0E00_0003);
    wr(12'h074, 32'h0);
    tick(1'b1, 2);
    rd(12'h074, 32'h0E00_0002);
    tick(1'b1, 1);
    rd(12'h074, 32'h0E00_0000);
    evt <= 7'h10;
    @(posedge clk);
    evt <= 7'h00;
    wr(12'h074, 32'hFE00_0000);
    rd(12'h074, 32'h2E00_0000);
    wr(12'h074, 32'h0100_0000);
    rd(12'h074, 32'h0000_0000);
    evt <= 7'h02;
    @(posedge clk);
    evt <= 7'h00;
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(12'h074, 32'h0400_0000);
    rd(12'h070, 32'h0000_0104);
    rd(12'h064, 32'h0007_7930);
    `chk(lat, 1)
    pw_n <= 1'b0;
    @(posedge clk);
    pw_n <= 1'b1;
    @(posedge clk);
    rd(12'h074, 32'h0E00_0000);
    wr(12'h070, 32'h0001_0000);
    wr(12'h070, 32'h0001_0200);
    rd(12'h070, 32'h0001_0000);
    wr(12'h070, 32'h0000_0200);
    rd(12'h070, 32'h0000_0200);
    bk_n <= 1'b0;
    @(posedge clk);
    bk_n <= 1'b1;
    @(posedge clk);
    rd(12'h070, 32'h0);
    end_sim();
  end
endmodule : sgb_clock_ctrl_test
